// ===== inc/pcr_defines.svh
// Purpose: Field positions and fixed values of the profiler capability words
// Assumes: Included by bare name from the capability report design file
// Notes: Definitions only
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

// ----------------------------------------
// Filter capability word layout
// ----------------------------------------
`define PCR_F_LATW_HI 4
`define PCR_F_LATW_LO 0
`define PCR_F_ADDR 5
`define PCR_F_RND_HI 8
`define PCR_F_RND_LO 6
`define PCR_F_VER_HI 15
`define PCR_F_VER_LO 9
`define PCR_F_MINBUF_HI 23
`define PCR_F_MINBUF_LO 16
`define PCR_F_RSV_HI 27
`define PCR_F_RSV_LO 24
`define PCR_F_BRPRED 28
`define PCR_F_IPRANGE 29
`define PCR_F_CLEVEL 30
`define PCR_F_CLAT 31

// ----------------------------------------
// Feature word layout
// ----------------------------------------
`define PCR_E_AVAIL 0
`define PCR_E_EV_HI 6
`define PCR_E_EV_LO 1
`define PCR_E_BRE 3
`define PCR_E_DME 4
`define PCR_E_RSV_HI 28
`define PCR_E_RSV_LO 7
`define PCR_E_CONT 29
`define PCR_E_PTSC 30
`define PCR_E_INT 31

// ----------------------------------------
// Fixed values
// ----------------------------------------
`define PCR_VERSION 7'h01
`define PCR_XMASK_BIT 62
`define PCR_LATW_MIN 5'h0a
`define PCR_LATW_MAX 5'h1f
`define PCR_RND_MAX 3'h4
`define PCR_CFG_RESET 32'h00000000
`define PCR_WORD_ZERO 32'h00000000

`endif

// ===== inc/pcr_pkg.sv
// Purpose: Types shared by the capability report design
// Assumes: Constants live in pcr_defines.svh
// Notes: Query and register selects
package pcr_pkg;

  // Which capability word a query returns
  typedef enum logic [1:0] {
    PCR_Q_APP,
    PCR_Q_FILTER,
    PCR_Q_FEATURE,
    PCR_Q_NONE
  } pcr_query_type;

  // Which model-specific register an access names
  typedef enum logic {
    PCR_M_CONFIG,
    PCR_M_CBPTR
  } pcr_msr_type;

endpackage : pcr_pkg

// ===== design/pcr_cap_gate.sv
// Purpose: Registered gating of a control field by its capability bit
// Assumes: Same clock domain as the caller
// Notes: Output reads zero while the capability is absent
`timescale 1ns/1ps
`default_nettype none

module pcr_cap_gate #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cap,
  input wire logic [WIDTH-1:0] ctl,
  output var logic [WIDTH-1:0] gated
);

  // ----------------------------------------
  // Gate
  // ----------------------------------------
  // A missing capability makes the control invisible downstream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gated <= '0;
    end else begin
      gated <= cap ? ctl : '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  gate_off_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cap |=> gated == '0) else $error("Control passed without capability");

endmodule : pcr_cap_gate

`default_nettype wire

// ===== design/pcr_capability_report.sv
// Purpose: Capability words, register gating and filter gating of the profiler
// Assumes: All inputs are on CLK_SYS; capabilities are fixed by parameters
// Notes: Queries and register accesses answer one cycle after the request
//
// Overview of operation
// R1: Latency width 10..31, zero without miss event
// R2: Address bit only with miss event support
// R3: Rounding 0..4, zero without miss event
// R4: Version field reads one
// R5: Minimum ring buffer in 32-record units
// R6: Prediction filtering only when capability set
// R7: Address range filtering ignored without capability
// R8: Cache level filtering only when capable
// R9: Latency filtering only when capable
// R10: Miss event implies latency or level filter
// R11: Supported bit copies extended flag 15
// R12: Event bits 1..6, reserved 7..28
// R13: Bits 29..31 report mode features
// R14: Registers accessible only with flag 15
// R15: Operating system enables mask bit 62
// R16: Newly enabled mask leaves profiler disabled
// R17: Application word: bit62 copy plus config
// R18: Reserved capability bits read zero
`timescale 1ns/1ps
`default_nettype none

`include "pcr_defines.svh"

module pcr_capability_report import pcr_pkg::*; #(
  parameter logic [4:0] LATENCY_BITS = 5'h10,
  parameter logic [2:0] LATENCY_ROUND = 3'h0,
  parameter logic [7:0] MIN_BUFFER_UNITS = 8'h00,
  parameter logic [5:0] EVENT_CAPS = 6'h3f,
  parameter logic MISS_ADDRESS = 1'b1,
  parameter logic BRANCH_PRED = 1'b1,
  parameter logic IP_RANGE = 1'b1,
  parameter logic CACHE_LEVEL = 1'b0,
  parameter logic CACHE_LATENCY = 1'b1,
  parameter logic CONT_SAMPLING = 1'b1,
  parameter logic TIMESTAMP = 1'b1,
  parameter logic THRESHOLD_IRQ = 1'b1,
  parameter int CB_WIDTH = 64,
  parameter int LAT_CTL_WIDTH = 12
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic EXT_FLAG_PROFILER,
  input wire logic QUERY_REQ,
  input wire logic [1:0] QUERY_SEL,
  output var logic QUERY_VALID,
  output var logic [31:0] QUERY_DATA,
  input wire logic XMASK_WE,
  input wire logic [63:0] XMASK_WDATA,
  input wire logic MSR_REQ,
  input wire logic MSR_WE,
  input wire logic MSR_SEL,
  input wire logic [CB_WIDTH-1:0] MSR_WDATA,
  output var logic MSR_ACK,
  output var logic MSR_FAULT,
  output var logic [CB_WIDTH-1:0] MSR_RDATA,
  output var logic [CB_WIDTH-1:0] CB_POINTER,
  output var logic PROFILER_ACTIVE,
  input wire logic MISPREDICTED_CTL,
  input wire logic PREDICTED_CTL,
  input wire logic IP_INVERT,
  input wire logic IP_ENABLE,
  input wire logic [CB_WIDTH-1:0] IP_LOW,
  input wire logic [CB_WIDTH-1:0] IP_HIGH,
  input wire logic CLEVEL_CTL,
  input wire logic [LAT_CTL_WIDTH-1:0] MIN_LATENCY,
  output var logic [1:0] BRANCH_FILTER,
  output var logic [1:0] IP_FILTER,
  output var logic [CB_WIDTH-1:0] IP_LOW_EFF,
  output var logic [CB_WIDTH-1:0] IP_HIGH_EFF,
  output var logic CLEVEL_FILTER,
  output var logic [LAT_CTL_WIDTH-1:0] MIN_LATENCY_EFF
);

  // ----------------------------------------
  // Capability words
  // ----------------------------------------
  logic dme;
  logic bre;
  logic lat_cap;
  logic lvl_cap;
  logic [31:0] filter_word;
  logic [31:0] feature_word;
  logic [31:0] app_word;
  logic [31:0] config_bits;
  logic mask_bit;
  logic [CB_WIDTH-1:0] cb_ptr;

  // Filter fields depending on miss-event support collapse to zero without it
  assign dme = EVENT_CAPS[`PCR_E_DME - `PCR_E_EV_LO];
  assign bre = EVENT_CAPS[`PCR_E_BRE - `PCR_E_EV_LO];
  // A miss event with neither filter is illegal, so latency filtering is forced
  assign lat_cap = dme & (CACHE_LATENCY | ~CACHE_LEVEL); // see R9 see R10
  assign lvl_cap = dme & CACHE_LEVEL; // see R8

  // Filter capability word, reserved bits held at zero
  always_comb begin
    filter_word = `PCR_WORD_ZERO; // see R18
    filter_word[`PCR_F_LATW_HI:`PCR_F_LATW_LO] = dme ? LATENCY_BITS : 5'h00; // see R1
    filter_word[`PCR_F_ADDR] = dme & MISS_ADDRESS; // see R2
    filter_word[`PCR_F_RND_HI:`PCR_F_RND_LO] = dme ? LATENCY_ROUND : 3'h0; // see R3
    filter_word[`PCR_F_VER_HI:`PCR_F_VER_LO] = `PCR_VERSION; // see R4
    filter_word[`PCR_F_MINBUF_HI:`PCR_F_MINBUF_LO] = MIN_BUFFER_UNITS; // see R5
    filter_word[`PCR_F_BRPRED] = bre & BRANCH_PRED; // see R6
    filter_word[`PCR_F_IPRANGE] = IP_RANGE; // see R7
    filter_word[`PCR_F_CLEVEL] = lvl_cap; // see R8
    filter_word[`PCR_F_CLAT] = lat_cap; // see R9
  end

  // Feature word, reserved bits held at zero
  always_comb begin
    feature_word = `PCR_WORD_ZERO; // see R18
    feature_word[`PCR_E_AVAIL] = EXT_FLAG_PROFILER; // see R11
    feature_word[`PCR_E_EV_HI:`PCR_E_EV_LO] = EVENT_CAPS; // see R12
    feature_word[`PCR_E_CONT] = CONT_SAMPLING; // see R13
    feature_word[`PCR_E_PTSC] = TIMESTAMP;
    feature_word[`PCR_E_INT] = THRESHOLD_IRQ;
  end

  // Application word: enable copy in bit 0, configuration above
  always_comb begin
    app_word = config_bits;
    app_word[`PCR_E_AVAIL] = mask_bit; // see R17
  end

  // ----------------------------------------
  // Query answer
  // ----------------------------------------
  // One-cycle answer; an unused select reads zero
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      QUERY_VALID <= 1'b0;
      QUERY_DATA <= `PCR_WORD_ZERO;
    end else begin
      QUERY_VALID <= QUERY_REQ;
      if (QUERY_REQ) begin
        unique case (pcr_query_type'(QUERY_SEL))
          PCR_Q_APP: QUERY_DATA <= app_word;
          PCR_Q_FILTER: QUERY_DATA <= filter_word;
          PCR_Q_FEATURE: QUERY_DATA <= feature_word;
          PCR_Q_NONE: QUERY_DATA <= `PCR_WORD_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Extended state mask bit
  // ----------------------------------------
  logic mask_rise;
  logic next_mask_bit;

  // The operating system writes the mask; only the profiler's bit is kept
  assign next_mask_bit = XMASK_WE ? XMASK_WDATA[`PCR_XMASK_BIT] : mask_bit; // see R15
  assign mask_rise = next_mask_bit & ~mask_bit;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mask_bit <= 1'b0;
    end else begin
      mask_bit <= next_mask_bit;
    end
  end

  // ----------------------------------------
  // Model-specific register access
  // ----------------------------------------
  logic msr_ok;
  logic cfg_wr;
  logic cfg_bad;
  logic ptr_wr;
  logic [31:0] cfg_allowed;

  // Only features that the feature word offers may be enabled
  assign cfg_allowed = {feature_word[`PCR_E_INT:`PCR_E_AVAIL + 1], 1'b0};
  assign msr_ok = MSR_REQ & EXT_FLAG_PROFILER; // see R14
  assign cfg_bad = |(MSR_WDATA[31:0] & ~cfg_allowed);
  assign cfg_wr = msr_ok & MSR_WE & (pcr_msr_type'(MSR_SEL) == PCR_M_CONFIG) & ~cfg_bad;
  assign ptr_wr = msr_ok & MSR_WE & (pcr_msr_type'(MSR_SEL) == PCR_M_CBPTR);

  // Configuration bits, a subset of the feature word
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      config_bits <= `PCR_CFG_RESET;
    end else if (cfg_wr) begin
      config_bits <= MSR_WDATA[31:0] & cfg_allowed; // see R17
    end
  end

  // Access answer; a refused access faults and reads zero
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      MSR_ACK <= 1'b0;
      MSR_FAULT <= 1'b0;
      MSR_RDATA <= '0;
    end else begin
      MSR_ACK <= MSR_REQ;
      MSR_FAULT <= MSR_REQ & (~EXT_FLAG_PROFILER | (MSR_WE & ~MSR_SEL & cfg_bad)); // see R14
      if (!msr_ok || MSR_WE) begin
        MSR_RDATA <= '0;
      end else if (pcr_msr_type'(MSR_SEL) == PCR_M_CONFIG) begin
        MSR_RDATA <= {{(CB_WIDTH-32){1'b0}}, config_bits};
      end else begin
        MSR_RDATA <= cb_ptr;
      end
    end
  end

  // ----------------------------------------
  // Control block pointer
  // ----------------------------------------
  // A fresh enable wins over a pointer write in the same cycle,
  // so the profiler always starts disabled
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cb_ptr <= '0;
    end else if (mask_rise || !next_mask_bit) begin
      cb_ptr <= '0; // see R16
    end else if (ptr_wr) begin
      cb_ptr <= MSR_WDATA;
    end
  end

  // Registered copies for the profiler engine
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CB_POINTER <= '0;
      PROFILER_ACTIVE <= 1'b0;
    end else begin
      CB_POINTER <= cb_ptr;
      PROFILER_ACTIVE <= mask_bit & (|cb_ptr); // see R16
    end
  end

  // ----------------------------------------
  // Filter gating
  // ----------------------------------------
  // Each control is dropped when its capability is absent
  pcr_cap_gate #(.WIDTH(2)) u_branch_gate ( // see R6
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .cap(filter_word[`PCR_F_BRPRED]),
    .ctl({MISPREDICTED_CTL, PREDICTED_CTL}),
    .gated(BRANCH_FILTER)
  );

  pcr_cap_gate #(.WIDTH(2 + 2 * CB_WIDTH)) u_ip_gate ( // see R7
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .cap(filter_word[`PCR_F_IPRANGE]),
    .ctl({IP_INVERT, IP_ENABLE, IP_LOW, IP_HIGH}),
    .gated({IP_FILTER, IP_LOW_EFF, IP_HIGH_EFF})
  );

  pcr_cap_gate #(.WIDTH(1)) u_level_gate ( // see R8
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .cap(lvl_cap),
    .ctl(CLEVEL_CTL),
    .gated(CLEVEL_FILTER)
  );

  pcr_cap_gate #(.WIDTH(LAT_CTL_WIDTH)) u_lat_gate ( // see R9
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .cap(lat_cap),
    .ctl(MIN_LATENCY),
    .gated(MIN_LATENCY_EFF)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic filt_q;
  logic feat_q;
  logic app_q;

  // Remember which word the last query asked for
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      filt_q <= 1'b0;
      feat_q <= 1'b0;
      app_q <= 1'b0;
    end else begin
      filt_q <= QUERY_REQ & (QUERY_SEL == PCR_Q_FILTER);
      feat_q <= QUERY_REQ & (QUERY_SEL == PCR_Q_FEATURE);
      app_q <= QUERY_REQ & (QUERY_SEL == PCR_Q_APP);
    end
  end

  latency_width_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R1
    filt_q |-> (dme ? (QUERY_DATA[`PCR_F_LATW_HI:`PCR_F_LATW_LO] inside
      {[`PCR_LATW_MIN:`PCR_LATW_MAX]}) : QUERY_DATA[`PCR_F_LATW_HI:`PCR_F_LATW_LO] == 5'h00))
    else $error("Latency width out of range");

  miss_address_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R2
    filt_q && !dme |-> !QUERY_DATA[`PCR_F_ADDR]) else $error("Address bit without miss event");

  rounding_range_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R3
    filt_q |-> QUERY_DATA[`PCR_F_RND_HI:`PCR_F_RND_LO] <= (dme ? `PCR_RND_MAX : 3'h0))
    else $error("Rounding bad");

  version_field_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R4
    filt_q |-> QUERY_DATA[`PCR_F_VER_HI:`PCR_F_VER_LO] == `PCR_VERSION)
    else $error("Version field wrong");

  // Minimum size is a plain copy of the build choice, zero meaning no minimum
  min_buffer_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R5
    filt_q |-> QUERY_DATA[`PCR_F_MINBUF_HI:`PCR_F_MINBUF_LO] == MIN_BUFFER_UNITS)
    else $error("Minimum buffer field wrong");

  branch_cap_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R6
    filt_q && !bre |-> !QUERY_DATA[`PCR_F_BRPRED]) else $error("Prediction bit without event");

  // Without the miss event neither cache filter may be offered
  cache_bits_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R9
    filt_q && !dme |-> !QUERY_DATA[`PCR_F_CLAT] && !QUERY_DATA[`PCR_F_CLEVEL])
    else $error("Cache filter without miss event");

  level_or_lat_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R10
    filt_q && dme |-> QUERY_DATA[`PCR_F_CLAT] || QUERY_DATA[`PCR_F_CLEVEL])
    else $error("No cache filter offered");

  supported_copy_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R11
    feat_q |-> QUERY_DATA[`PCR_E_AVAIL] == $past(EXT_FLAG_PROFILER))
    else $error("Supported bit wrong");

  event_bits_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R12
    feat_q |-> QUERY_DATA[`PCR_E_EV_HI:`PCR_E_EV_LO] == EVENT_CAPS)
    else $error("Event support bits wrong");

  mode_bits_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R13
    feat_q |-> QUERY_DATA[`PCR_E_INT:`PCR_E_CONT] == {THRESHOLD_IRQ, TIMESTAMP, CONT_SAMPLING})
    else $error("Mode feature bits wrong");

  reserved_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R18
    (filt_q |-> QUERY_DATA[`PCR_F_RSV_HI:`PCR_F_RSV_LO] == 4'h0) and
    (feat_q |-> QUERY_DATA[`PCR_E_RSV_HI:`PCR_E_RSV_LO] == 22'h000000))
    else $error("Reserved bits not zero");

  msr_gated_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R14
    MSR_REQ && !EXT_FLAG_PROFILER |=> MSR_ACK && MSR_FAULT && MSR_RDATA == '0)
    else $error("Register reachable without flag");

  enable_clears_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R16
    mask_rise |=> cb_ptr == '0 ##1 !PROFILER_ACTIVE) else $error("Enable left profiler on");

  app_copy_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R17
    app_q |-> QUERY_DATA[`PCR_E_AVAIL] == $past(mask_bit) &&
      (QUERY_DATA[`PCR_E_INT:`PCR_E_AVAIL + 1] & ~feature_word[`PCR_E_INT:`PCR_E_AVAIL + 1]) == '0)
    else $error("Application word wrong");

endmodule : pcr_capability_report

`default_nettype wire

// ===== tb/pcr_capability_report_bench.sv
// Purpose: Self-checking bench for the profiler capability report block
// Assumes: Two instances with different capability parameters share the query port
// Notes: A small model of config, mask bit and pointer predicts the first part's register answers and both parts' application-word answers
`timescale 1ns/1ps
`default_nettype none

module pcr_capability_report_bench;
  // ----------------------------------------
  // Expected words worked out from the field layout
  // ----------------------------------------
  localparam logic [31:0] FEAT_A = {3'b111, 22'h0, 6'h3f, 1'b0};
  localparam logic [31:0] FEAT_B = {3'b110, 22'h0, 6'h23, 1'b0};
  localparam logic [31:0] FIL_A = {4'hf, 4'h0, 8'hff, 7'h01, 3'h4, 1'b1, 5'h1f};
  // Miss and branch events absent: their fields must read zero
  localparam logic [31:0] FIL_B = {4'h0, 4'h0, 8'h01, 7'h01, 3'h0, 1'b0, 5'h00};
  // Capability sets of the two builds
  localparam logic [4:0] LAT_A = 5'h1f;
  localparam logic [2:0] RND_A = 3'h4;
  localparam logic [7:0] BUF_A = 8'hff;
  localparam logic [4:0] LAT_B = 5'h0c;
  localparam logic [2:0] RND_B = 3'h2;
  localparam logic [7:0] BUF_B = 8'h01;
  localparam logic [5:0] EVENTS_B = 6'h23;
  localparam logic CAP_ON = 1'b1;
  localparam logic CAP_OFF = 1'b0;

  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic EXT_FLAG_PROFILER = 1'b0;
  logic QUERY_REQ = 1'b0;
  logic [1:0] QUERY_SEL = 2'h0;
  logic XMASK_WE = 1'b0;
  logic [63:0] XMASK_WDATA = 64'h0;
  logic MSR_REQ = 1'b0;
  logic MSR_WE = 1'b0;
  logic MSR_SEL = 1'b0;
  logic [63:0] MSR_WDATA = 64'h0;
  logic MISPREDICTED_CTL = 1'b0, PREDICTED_CTL = 1'b0, IP_INVERT = 1'b0, IP_ENABLE = 1'b0;
  logic [63:0] IP_LOW = 64'h0, IP_HIGH = 64'h0;
  logic CLEVEL_CTL = 1'b0;
  logic [11:0] MIN_LATENCY = 12'h0;
  logic QUERY_VALID, MSR_ACK, MSR_FAULT, PROFILER_ACTIVE, CLEVEL_FILTER;
  logic [31:0] QUERY_DATA;
  logic [63:0] MSR_RDATA, CB_POINTER, IP_LOW_EFF, IP_HIGH_EFF;
  logic [1:0] BRANCH_FILTER, IP_FILTER;
  logic [11:0] MIN_LATENCY_EFF;
  logic b_valid, b_cl;
  logic [31:0] b_data;
  logic [1:0] b_br, b_ip;
  logic [63:0] b_lo, b_hi;
  logic [11:0] b_ml;
  int bad_count = 0;
  int checks_done = 0;
  logic chk_on = 1'b0;
  logic [31:0] m_cfg = 32'h0;
  logic [31:0] mb_cfg = 32'h0;
  logic m_mask = 1'b0;
  logic [63:0] m_ptr = 64'h0;

  // 200 MHz core clock
  always #2.5 CLK_SYS = ~CLK_SYS;

  // ----------------------------------------
  // Devices under test
  // ----------------------------------------
  pcr_capability_report #(.LATENCY_BITS(LAT_A), .LATENCY_ROUND(RND_A),
    .MIN_BUFFER_UNITS(BUF_A), .CACHE_LEVEL(CAP_ON)) u_pcr_capability_report (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .EXT_FLAG_PROFILER(EXT_FLAG_PROFILER),
    .QUERY_REQ(QUERY_REQ), .QUERY_SEL(QUERY_SEL), .QUERY_VALID(QUERY_VALID),
    .QUERY_DATA(QUERY_DATA), .XMASK_WE(XMASK_WE), .XMASK_WDATA(XMASK_WDATA),
    .MSR_REQ(MSR_REQ), .MSR_WE(MSR_WE), .MSR_SEL(MSR_SEL), .MSR_WDATA(MSR_WDATA),
    .MSR_ACK(MSR_ACK), .MSR_FAULT(MSR_FAULT), .MSR_RDATA(MSR_RDATA),
    .CB_POINTER(CB_POINTER), .PROFILER_ACTIVE(PROFILER_ACTIVE),
    .MISPREDICTED_CTL(MISPREDICTED_CTL), .PREDICTED_CTL(PREDICTED_CTL),
    .IP_INVERT(IP_INVERT), .IP_ENABLE(IP_ENABLE), .IP_LOW(IP_LOW), .IP_HIGH(IP_HIGH),
    .CLEVEL_CTL(CLEVEL_CTL), .MIN_LATENCY(MIN_LATENCY), .BRANCH_FILTER(BRANCH_FILTER),
    .IP_FILTER(IP_FILTER), .IP_LOW_EFF(IP_LOW_EFF), .IP_HIGH_EFF(IP_HIGH_EFF),
    .CLEVEL_FILTER(CLEVEL_FILTER), .MIN_LATENCY_EFF(MIN_LATENCY_EFF));

  // Reduced part: register answers unwatched, its config is judged through queries
  pcr_capability_report #(.LATENCY_BITS(LAT_B), .LATENCY_ROUND(RND_B),
    .MIN_BUFFER_UNITS(BUF_B), .EVENT_CAPS(EVENTS_B), .IP_RANGE(CAP_OFF), .CACHE_LEVEL(CAP_ON),
    .CONT_SAMPLING(CAP_OFF)) u_pcr_capability_report_b (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .EXT_FLAG_PROFILER(EXT_FLAG_PROFILER),
    .QUERY_REQ(QUERY_REQ), .QUERY_SEL(QUERY_SEL), .QUERY_VALID(b_valid),
    .QUERY_DATA(b_data), .XMASK_WE(XMASK_WE), .XMASK_WDATA(XMASK_WDATA),
    .MSR_REQ(MSR_REQ), .MSR_WE(MSR_WE), .MSR_SEL(MSR_SEL), .MSR_WDATA(MSR_WDATA),
    .MSR_ACK(), .MSR_FAULT(), .MSR_RDATA(), .CB_POINTER(), .PROFILER_ACTIVE(),
    .MISPREDICTED_CTL(MISPREDICTED_CTL), .PREDICTED_CTL(PREDICTED_CTL),
    .IP_INVERT(IP_INVERT), .IP_ENABLE(IP_ENABLE), .IP_LOW(IP_LOW), .IP_HIGH(IP_HIGH),
    .CLEVEL_CTL(CLEVEL_CTL), .MIN_LATENCY(MIN_LATENCY), .BRANCH_FILTER(b_br),
    .IP_FILTER(b_ip), .IP_LOW_EFF(b_lo), .IP_HIGH_EFF(b_hi),
    .CLEVEL_FILTER(b_cl), .MIN_LATENCY_EFF(b_ml));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // Entered just after a falling edge; answer is judged one cycle later
  task automatic query(input logic [1:0] sel, input logic [31:0] ea, input logic [31:0] eb);
    QUERY_REQ = 1'b1;
    QUERY_SEL = sel;
    @(negedge CLK_SYS);
    QUERY_REQ = 1'b0;
    check({b_valid, QUERY_VALID}, 2'b11);
    check(QUERY_DATA, ea);
    check(b_data, eb);
    // Let an edge pass so the next strobe is a fresh pulse
    @(negedge CLK_SYS);
  endtask : query

  task automatic msr(input logic we, input logic sel, input logic [63:0] wd,
                     input logic ef, input logic [63:0] er);
    MSR_REQ = 1'b1;
    MSR_WE = we;
    MSR_SEL = sel;
    MSR_WDATA = wd;
    @(negedge CLK_SYS);
    MSR_REQ = 1'b0;
    check({MSR_ACK, MSR_FAULT}, {1'b1, ef});
    check(MSR_RDATA, er);
    @(negedge CLK_SYS);
  endtask : msr

  // Only bits the feature word offers may be enabled; bit 0 never
  task automatic cfg_write(input logic [31:0] v);
    logic f;
    f = !EXT_FLAG_PROFILER || ((v & ~FEAT_A) != 32'h0);
    if (!f) m_cfg = v;
    // The reduced part offers fewer features, so it refuses more
    if (EXT_FLAG_PROFILER && (v & ~FEAT_B) == 32'h0) mb_cfg = v;
    msr(1'b1, 1'b0, {32'h0, v}, f, 64'h0);
  endtask : cfg_write

  task automatic ptr_write(input logic [63:0] p);
    if (EXT_FLAG_PROFILER && m_mask) m_ptr = p;
    msr(1'b1, 1'b1, p, !EXT_FLAG_PROFILER, 64'h0);
  endtask : ptr_write

  // Read lands two cycles after a register write and one after a mask write, so the pointer copy is due
  task automatic ptr_read;
    msr(1'b0, 1'b1, 64'h0, 1'b0, m_ptr);
    check(CB_POINTER, m_ptr);
    check(PROFILER_ACTIVE, m_mask && m_ptr != 64'h0);
  endtask : ptr_read

  task automatic mask_write(input logic b);
    XMASK_WE = 1'b1;
    XMASK_WDATA = {1'b0, b, 62'h0};
    @(negedge CLK_SYS);
    XMASK_WE = 1'b0;
    if (b != m_mask || !b) m_ptr = 64'h0;
    m_mask = b;
  endtask : mask_write

  // ----------------------------------------
  // Filter gating: random controls, judged one cycle after they are taken
  // ----------------------------------------
  always @(negedge CLK_SYS) begin
    if (chk_on) begin
      check(BRANCH_FILTER, {MISPREDICTED_CTL, PREDICTED_CTL});
      check(IP_FILTER, {IP_INVERT, IP_ENABLE});
      check(IP_LOW_EFF, IP_LOW);
      check(IP_HIGH_EFF, IP_HIGH);
      check(CLEVEL_FILTER, CLEVEL_CTL);
      check(MIN_LATENCY_EFF, MIN_LATENCY);
      check({b_br, b_ip, b_cl, b_ml}, 17'h0);
      check(b_lo | b_hi, 64'h0);
    end
    {MISPREDICTED_CTL, PREDICTED_CTL, IP_INVERT, IP_ENABLE, CLEVEL_CTL} = 5'($urandom);
    IP_LOW = {$urandom, $urandom};
    IP_HIGH = {$urandom, $urandom};
    MIN_LATENCY = 12'($urandom);
  end

  // Hang guard
  initial begin
    #100000;
    bad_count++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int seed_val;
    int bad_bits[4];
    seed_val = $urandom(53044);
    bad_bits = '{0, 7, 15, 28};
    repeat (12) @(negedge CLK_SYS);
    RSTN = 1'b1;
    @(negedge CLK_SYS);
    chk_on = 1'b1;
    query(2'h0, 32'h0, 32'h0);
    query(2'h1, FIL_A, FIL_B);
    query(2'h2, FEAT_A, FEAT_B);
    query(2'h3, 32'h0, 32'h0);
    msr(1'b0, 1'b0, 64'h0, 1'b1, 64'h0);
    cfg_write(FEAT_A);
    ptr_write(64'h55);
    EXT_FLAG_PROFILER = 1'b1;
    query(2'h2, FEAT_A | 32'h1, FEAT_B | 32'h1);
    query(2'h1, FIL_A, FIL_B);
    // A setting that both parts accept
    cfg_write(FEAT_B);
    query(2'h0, {m_cfg[31:1], m_mask}, {mb_cfg[31:1], m_mask});
    for (int i = 0; i < 4; i++) begin
      cfg_write($urandom & FEAT_A);
      query(2'h0, {m_cfg[31:1], m_mask}, {mb_cfg[31:1], m_mask});
      msr(1'b0, 1'b0, 64'h0, 1'b0, {32'h0, m_cfg});
    end
    // Illegal bits fault and leave the register as it was
    foreach (bad_bits[k]) cfg_write(m_cfg | (32'h1 << bad_bits[k]));
    msr(1'b0, 1'b0, 64'h0, 1'b0, {32'h0, m_cfg});
    ptr_write({$urandom, $urandom} | 64'h1);
    ptr_read();
    mask_write(1'b1);
    query(2'h0, {m_cfg[31:1], 1'b1}, {mb_cfg[31:1], 1'b1});
    ptr_write({$urandom, $urandom} | 64'h1);
    ptr_read();
    mask_write(1'b0);
    ptr_read();
    // Mask rise and pointer write in one cycle: the rise must win
    XMASK_WE = 1'b1;
    XMASK_WDATA = {1'b0, 1'b1, 62'h0};
    msr(1'b1, 1'b1, 64'hf0, 1'b0, 64'h0);
    XMASK_WE = 1'b0;
    m_mask = 1'b1;
    ptr_read();
    ptr_write({$urandom, $urandom} | 64'h1);
    mask_write(1'b1);
    ptr_read();
    close_out();
  end
endmodule : pcr_capability_report_bench

`default_nettype wire
